//--- verilog/ascs_pkg.sv
// Shared constants and types for the serial init and clock select block
package ascs_pkg;
    localparam int CODE_BITS = 4;
    localparam int RESULT_BITS = 10;
    localparam int IDX_BITS = 4;
    localparam logic [3:0] CODE_POWER_DOWN = 4'h8;
    localparam logic [3:0] CODE_RATE_FAST = 4'h9;
    localparam logic [3:0] CODE_RATE_SLOW = 4'ha;
    localparam logic [3:0] CODE_RESET = 4'h0;
    localparam logic [2:0] CNT_RESET = 3'h0;
    localparam logic [3:0] IDX_RESET = 4'h0;
    localparam logic MODE_PROCESSOR = 1'b1;
    localparam logic MODE_SIGNAL_PROC = 1'b0;
    localparam logic MODE_RESET = MODE_SIGNAL_PROC;
    localparam logic DONE_RESET = 1'b1;
    localparam logic INVERT_RESET = 1'b1;
    localparam logic RATE_FAST_RESET = 1'b0;
    localparam logic [9:0] RESULT_RESET = 10'h000;

    // What the link hands to the system side at the end of a frame
    typedef struct packed {
        logic [3:0] code;
        logic mode;
    } ascs_frame_t;

    // Conversion result from the converter core
    typedef struct packed {
        logic valid;
        logic [9:0] data;
    } ascs_result_t;
endpackage : ascs_pkg

//--- verilog/ascs_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module ascs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic [WIDTH-1:0] level_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        meta_reg <= level_in;
        level_out <= meta_reg;
    end
endmodule : ascs_sync

//--- verilog/ascs_serial_init.sv
// Serial port init, mode capture and shift-clock edge selection
// Notes on behaviour
// (R1) Host opens first cycle by lowering select
// (R2) Done flag high from reset until start
// (R3) Input register cleared at reset
// (R4) Host discards first result after reset
// (R5) Select high then low restarts I/O cycle
// (R6) Host discards first result after power-down
// (R7) Host programs rate after power-up
// (R8) Pending flag cleared at closing select rise
// (R9) Input register clocked by shift clock
// (R10) Invert pin low inverts input sampling clock
// (R11) Frame sync at select fall picks mode
// (R12) Invert high: output/sample on opposite edges
// (R13) Invert low: output and sample share edge
// (R14) Pending set on start rise, cleared on select rise
// (R15) Codes 9h/ah pick fast/slow rate, persist
// (R16) Code 8h powers down; select fall wakes
`timescale 1ns/1ps
module ascs_serial_init (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic frame_sync_in,
    input wire logic data_in,
    input wire logic input_clock_invert_pin_in,
    input wire logic sample_start_n_in,
    input wire ascs_pkg::ascs_result_t result_in,
    input wire logic conv_complete_in,
    output logic data_out,
    output logic conv_done_out,
    output logic conv_start_out,
    output logic extended_sample_pending_out,
    output logic rate_fast_out,
    output logic power_down_out,
    output logic host_processor_mode_out,
    output logic [3:0] input_code_out
);
    localparam int CB = ascs_pkg::CODE_BITS;
    localparam int RB = ascs_pkg::RESULT_BITS;

    function automatic logic result_bit(input logic [9:0] word,
                                        input logic [3:0] idx);
        logic b;
        b = 1'b0;
        if (idx < 4'(RB)) begin
            b = word[4'(RB - 1) - idx];
        end
        return b;
    endfunction : result_bit

    // ---------------- Link side, on the shift clock ----------------
    logic link_clr;
    logic inv_link;
    logic inv_sys;
    logic mode_reg;
    logic sample_rise;
    logic [2:0] rise_cnt_reg;
    logic [2:0] fall_cnt_reg;
    logic [3:0] rise_shift_reg;
    logic [3:0] fall_shift_reg;
    logic [3:0] rise_code_reg;
    logic [3:0] fall_code_reg;
    logic [3:0] rise_idx_reg;
    logic [3:0] fall_idx_reg;
    logic [9:0] hold_reg;
    ascs_pkg::ascs_frame_t link_frame;

    // Select high holds the frame counters at zero, so a fresh
    // cycle starts at every select fall.
    assign link_clr = cs_n_in | reset_in; // [R5]

    // Static pin: brought onto clk_in and latched at each select fall,
    // as the shift clock runs too few edges to clock a synchroniser.
    ascs_sync #(.WIDTH(1)) u_inv_sync (
        .clk_in(clk_in),
        .level_in(input_clock_invert_pin_in),
        .level_out(inv_sys)
    );

    // Frame sync is looked at only on the select fall
    always_ff @(negedge cs_n_in or posedge reset_in) begin
        if (reset_in) begin
            mode_reg <= ascs_pkg::MODE_RESET;
            inv_link <= ascs_pkg::INVERT_RESET;
        end else begin
            mode_reg <= frame_sync_in; // [R11]
            inv_link <= inv_sys; // [R10]
        end
    end

    // Processor mode samples on rise unless inverted; signal
    // processor mode the opposite way.
    assign sample_rise = (mode_reg == inv_link); // [R10] [R12] [R13]

    // Rising-edge capture path of the input register
    always_ff @(posedge sclk_in or posedge link_clr) begin
        if (link_clr) begin
            rise_cnt_reg <= ascs_pkg::CNT_RESET;
        end else if (sample_rise && rise_cnt_reg < 3'(CB)) begin
            rise_cnt_reg <= rise_cnt_reg + 3'h1; // [R9]
        end
    end

    always_ff @(posedge sclk_in) begin
        if (sample_rise && rise_cnt_reg < 3'(CB)) begin
            rise_shift_reg <= {rise_shift_reg[2:0], data_in};
        end
    end

    always_ff @(posedge sclk_in or posedge reset_in) begin
        if (reset_in) begin
            rise_code_reg <= ascs_pkg::CODE_RESET; // [R3]
        end else if (sample_rise && rise_cnt_reg == 3'(CB - 1)) begin
            rise_code_reg <= {rise_shift_reg[2:0], data_in};
        end
    end

    // Falling-edge capture path of the input register
    always_ff @(negedge sclk_in or posedge link_clr) begin
        if (link_clr) begin
            fall_cnt_reg <= ascs_pkg::CNT_RESET;
        end else if (!sample_rise && fall_cnt_reg < 3'(CB)) begin
            fall_cnt_reg <= fall_cnt_reg + 3'h1; // [R9]
        end
    end

    always_ff @(negedge sclk_in) begin
        if (!sample_rise && fall_cnt_reg < 3'(CB)) begin
            fall_shift_reg <= {fall_shift_reg[2:0], data_in};
        end
    end

    always_ff @(negedge sclk_in or posedge reset_in) begin
        if (reset_in) begin
            fall_code_reg <= ascs_pkg::CODE_RESET; // [R3]
        end else if (!sample_rise && fall_cnt_reg == 3'(CB - 1)) begin
            fall_code_reg <= {fall_shift_reg[2:0], data_in};
        end
    end

    // Output index: processor mode steps on fall, the other on rise
    always_ff @(posedge sclk_in or posedge link_clr) begin
        if (link_clr) begin
            rise_idx_reg <= ascs_pkg::IDX_RESET;
        end else if (mode_reg == ascs_pkg::MODE_SIGNAL_PROC &&
                     rise_idx_reg < 4'(RB)) begin
            rise_idx_reg <= rise_idx_reg + 4'h1; // [R12] [R13]
        end
    end

    always_ff @(negedge sclk_in or posedge link_clr) begin
        if (link_clr) begin
            fall_idx_reg <= ascs_pkg::IDX_RESET;
        end else if (mode_reg == ascs_pkg::MODE_PROCESSOR &&
                     fall_idx_reg < 4'(RB)) begin
            fall_idx_reg <= fall_idx_reg + 4'h1; // [R12] [R13]
        end
    end

    // Two edge paths feed one pin, so the pin is a select of two
    // registered indices rather than a single flop.
    assign data_out = result_bit(hold_reg,
        mode_reg ? fall_idx_reg : rise_idx_reg);

    // Codes stay stable from the last bit until the next frame
    assign link_frame.code = sample_rise ? rise_code_reg : fall_code_reg;
    assign link_frame.mode = mode_reg;

    // ---------------- System side, on clk_in ----------------
    logic [1:0] pins_sync;
    logic cs_n_s;
    logic start_n_s;
    logic cs_n_d_reg;
    logic start_n_d_reg;
    logic cs_rise;
    logic cs_fall;
    logic start_rise;
    logic pending_next;
    logic pending_at_fall_reg;
    logic frame_closes;
    logic [4:0] frame_meta_reg;
    ascs_pkg::ascs_frame_t frame_sys_reg;
    logic is_pd_code;
    logic is_fast_code;
    logic is_slow_code;
    logic start_conv;

    ascs_sync #(.WIDTH(2)) u_pin_sync (
        .clk_in(clk_in),
        .level_in({cs_n_in, sample_start_n_in}),
        .level_out(pins_sync)
    );

    assign cs_n_s = pins_sync[1];
    assign start_n_s = pins_sync[0];
    assign cs_rise = cs_n_s & ~cs_n_d_reg;
    assign cs_fall = ~cs_n_s & cs_n_d_reg;
    assign start_rise = start_n_s & ~start_n_d_reg;

    // Frame word is quiet while select is high, so a plain two-flop
    // capture of the whole word is safe here.
    always_ff @(posedge clk_in) begin
        frame_meta_reg <= link_frame;
        frame_sys_reg <= frame_meta_reg;
    end

    assign frame_closes = cs_rise;
    assign is_pd_code = frame_sys_reg.code == ascs_pkg::CODE_POWER_DOWN;
    assign is_fast_code = frame_sys_reg.code == ascs_pkg::CODE_RATE_FAST;
    assign is_slow_code = frame_sys_reg.code == ascs_pkg::CODE_RATE_SLOW;
    assign start_conv = frame_closes & ~pending_at_fall_reg &
                        ~is_pd_code & ~is_fast_code & ~is_slow_code;

    // A start rise in the same cycle as a select rise wins
    assign pending_next = start_rise ? 1'b1 :
        (cs_rise ? 1'b0 : extended_sample_pending_out); // [R8] [R14]

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cs_n_d_reg <= 1'b1;
            start_n_d_reg <= 1'b1;
            pending_at_fall_reg <= 1'b0;
            extended_sample_pending_out <= 1'b0;
            conv_start_out <= 1'b0;
            host_processor_mode_out <= ascs_pkg::MODE_RESET;
            input_code_out <= ascs_pkg::CODE_RESET; // [R3]
        end else begin
            cs_n_d_reg <= cs_n_s;
            start_n_d_reg <= start_n_s;
            extended_sample_pending_out <= pending_next;
            conv_start_out <= start_conv;
            if (cs_fall) begin
                pending_at_fall_reg <= extended_sample_pending_out;
            end
            if (frame_closes) begin
                host_processor_mode_out <= frame_sys_reg.mode; // [R11]
                input_code_out <= frame_sys_reg.code;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            conv_done_out <= ascs_pkg::DONE_RESET; // [R2]
            rate_fast_out <= ascs_pkg::RATE_FAST_RESET;
            power_down_out <= 1'b0;
        end else begin
            if (start_conv) begin
                conv_done_out <= 1'b0; // [R2]
            end else if (conv_complete_in) begin
                conv_done_out <= 1'b1;
            end
            if (frame_closes && is_fast_code) begin
                rate_fast_out <= 1'b1; // [R15]
            end else if (frame_closes && is_slow_code) begin
                rate_fast_out <= 1'b0; // [R15]
            end
            // Waking leaves the rate alone
            if (cs_fall) begin
                power_down_out <= 1'b0; // [R16]
            end else if (frame_closes && is_pd_code) begin
                power_down_out <= 1'b1; // [R16]
            end
        end
    end

    // Result is only swapped while select is high so a frame never
    // sees a torn word; a result arriving mid-frame is lost.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            hold_reg <= ascs_pkg::RESULT_RESET; // [R4]
        end else if (result_in.valid && cs_n_s && cs_n_in) begin
            hold_reg <= result_in.data;
        end
    end
endmodule : ascs_serial_init

//--- test/ascs_host_model.sv
// Host serial port model: select, frame sync, shift clock and data
`timescale 1ns/1ps
module ascs_host_model (
    input wire logic dev_data_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic frame_sync_out,
    output logic data_out,
    output logic first_bit_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        frame_sync_out = 1'b1;
        data_out = 1'b0;
        first_bit_out = 1'b0;
    end
    // Data moves just after the sampling edge, so a wrong edge is seen only for rise sampling (mode == inv)
    task automatic send(input logic mode, input logic inv,
                        input logic [3:0] code);
        frame_sync_out = mode;
        #10 cs_n_out = 1'b0;
        data_out = code[3];
        #20 first_bit_out = dev_data_in; // t_conv checks it as the result's top bit
        #280;
        for (int i = 2; i >= -1; i--) begin
            #31.5 sclk_out = 1'b1;
            #31 if (mode == inv) data_out = (i >= 0) ? code[i] : ~code[0];
            #31.5 sclk_out = 1'b0;
            #31 if (mode != inv) data_out = (i >= 0) ? code[i] : ~code[0];
        end
        #100 cs_n_out = 1'b1;
        frame_sync_out = 1'b1;
        #300;
    endtask : send
endmodule : ascs_host_model

//--- test/ascs_serial_init_props.sv
// Port-level checks for the serial init block
`timescale 1ns/1ps
module ascs_serial_init_props (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic cs_n_in,
    input wire logic sample_start_n_in,
    input wire logic conv_complete_in,
    input wire logic conv_done_out,
    input wire logic conv_start_out,
    input wire logic extended_sample_pending_out,
    input wire logic rate_fast_out,
    input wire logic power_down_out,
    input wire logic host_processor_mode_out,
    input wire logic [3:0] input_code_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff reset_in;
    done_reset_a: assert property ($past(reset_in) |-> conv_done_out)
        else $error("done low after reset");
    code_reset_a: assert property ($past(reset_in) |-> !input_code_out)
        else $error("code not clear after reset");
    done_rise_a: assert property (
        $rose(conv_done_out) |-> $past(conv_complete_in))
        else $error("done rose without completion");
    start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse too long");
    code_hold_a: assert property (
        $changed(input_code_out) |-> $past(cs_n_in, 2))
        else $error("code changed inside frame");
    mode_hold_a: assert property (
        $changed(host_processor_mode_out) |-> $past(cs_n_in, 2))
        else $error("mode changed inside frame");
    rate_fast_a: assert property (
        input_code_out == 4'h9 && $past(input_code_out) == 4'h9
        |-> rate_fast_out)
        else $error("fast rate not held");
    rate_slow_a: assert property (
        input_code_out == 4'ha && $past(input_code_out) == 4'ha
        |-> !rate_fast_out)
        else $error("slow rate not held");
    pd_enter_a: assert property (
        $rose(power_down_out) |-> ##[0:1] input_code_out == 4'h8)
        else $error("power-down without its code");
    pend_clear_a: assert property (
        $fell(extended_sample_pending_out) |-> $past(cs_n_in, 2))
        else $error("pending cleared inside frame");
    // Two sync flops and the pending register put the pin rise 3-4 back
    pend_set_a: assert property (
        $rose(extended_sample_pending_out)
        |-> $past(sample_start_n_in, 3) && !$past(sample_start_n_in, 4))
        else $error("pending set without start rise");
    cover property (conv_start_out);
    cover property ($rose(power_down_out));
    cover property ($rose(extended_sample_pending_out));
endmodule : ascs_serial_init_props
bind ascs_serial_init ascs_serial_init_props ascs_serial_init_props_inst (.*);

//--- test/ascs_serial_init_tb.sv
// Self-checking bench for the serial init block
`timescale 1ns/1ps
module ascs_serial_init_tb;
    logic clk_in = 1'b0;
    logic reset_in = 1'b0;
    logic inv = 1'b1;
    logic start_n = 1'b1;
    logic complete = 1'b0;
    ascs_pkg::ascs_result_t result = '0;
    logic sclk, cs_n, fs, din, dout, first_bit;
    logic done, start, pend, fast, pd, mode;
    logic [3:0] code;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int starts = 0;
    always #50 clk_in = ~clk_in;
    ascs_host_model ascs_host_model_inst (.dev_data_in(dout), .sclk_out(sclk),
        .cs_n_out(cs_n), .frame_sync_out(fs), .data_out(din),
        .first_bit_out(first_bit));
    ascs_serial_init ascs_serial_init_inst (.clk_in(clk_in),
        .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .frame_sync_in(fs), .data_in(din), .input_clock_invert_pin_in(inv),
        .sample_start_n_in(start_n), .result_in(result),
        .conv_complete_in(complete), .data_out(dout), .conv_done_out(done),
        .conv_start_out(start), .extended_sample_pending_out(pend),
        .rate_fast_out(fast), .power_down_out(pd),
        .host_processor_mode_out(mode), .input_code_out(code));
    task automatic check(input string what, input logic [3:0] exp,
                         input logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude
    // Outputs settle 2-3 clocks after select rises, so wait six
    task automatic frame(input logic m, input logic [3:0] c);
        @(posedge clk_in);
        ascs_host_model_inst.send(m, inv, c);
        repeat (6) @(posedge clk_in);
        #1;
    endtask : frame
    task automatic t_reset;
        check("done", 4'h1, done);
        check("code", 4'h0, code);
        check("pend", 4'h0, pend);
        check("pd", 4'h0, pd);
    endtask : t_reset
    task automatic t_edges;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            inv <= i[1];
            // Pin passes two clk_in flops before the select fall latches it
            repeat (3) @(posedge clk_in);
            frame(i[0], 4'h9);
            check("fast", 4'h1, fast);
            check("mode", {3'h0, i[0]}, mode);
            frame(i[0], 4'ha);
            check("slow", 4'h0, fast);
        end
    endtask : t_edges
    task automatic t_power;
        frame(1'b1, 4'h9);
        frame(1'b1, 4'h8);
        check("pd", 4'h1, pd);
        check("fast", 4'h1, fast);
        frame(1'b1, 4'h3);
        check("pd", 4'h0, pd);
    endtask : t_power
    task automatic t_conv;
        int n;
        @(posedge clk_in);
        result <= '{valid: 1'b1, data: 10'h2aa};
        @(posedge clk_in);
        result <= '0;
        n = starts;
        frame(1'b1, 4'h3);
        check("first bit", 4'h1, first_bit);
        check("starts", 4'h1, 4'(starts - n));
        check("done", 4'h0, done);
        complete <= 1'b1;
        @(posedge clk_in);
        complete <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 check("done", 4'h1, done);
    endtask : t_conv
    task automatic t_pend;
        int n;
        @(posedge clk_in);
        start_n <= 1'b0;
        repeat (3) @(posedge clk_in);
        start_n <= 1'b1;
        repeat (6) @(posedge clk_in);
        #1 check("pend", 4'h1, pend);
        n = starts;
        frame(1'b0, 4'h3);
        check("starts", 4'h0, 4'(starts - n));
        check("pend", 4'h0, pend);
    endtask : t_pend
    always @(posedge clk_in) begin
        cycles++;
        if (start === 1'b1) starts++;
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        // Raised by NBA so the link flops see a real reset edge
        reset_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1 t_reset();
        t_edges();
        t_power();
        t_conv();
        t_pend();
        conclude();
    end
endmodule : ascs_serial_init_tb
